/* File: vsq_pkg.sv */
package vsq_pkg;

    // ------------------------------------------------------------
    // Port addresses and register indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_PORT    = 16'h03c4;
    localparam logic [15:0] DATA_PORT   = 16'h03c5;
    localparam logic [2:0]  IDX_RESET   = 3'h0;
    localparam logic [2:0]  IDX_CLKMODE = 3'h1;
    localparam logic [2:0]  IDX_PMASK   = 3'h2;
    localparam logic [2:0]  IDX_FONT    = 3'h3;
    localparam logic [2:0]  IDX_MEMMODE = 3'h4;
    localparam logic [2:0]  IDX_CCHOLD  = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RST_ASYNC_BIT  = 0;
    localparam int RST_SYNC_BIT   = 1;
    localparam int CM_NARROW_BIT  = 0;
    localparam int CM_SLOAD_BIT   = 2;
    localparam int CM_DCDIV_BIT   = 3;
    localparam int CM_SHIFT4_BIT  = 4;
    localparam int CM_SCROFF_BIT  = 5;
    localparam int MM_EXTMEM_BIT  = 1;
    localparam int MM_ODDEVEN_BIT = 2;
    localparam int MM_CHAIN4_BIT  = 3;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] INDEX_RST   = 8'h00;
    localparam logic [7:0] RESET_RST   = 8'h03;
    localparam logic [7:0] CLKMODE_RST = 8'h00;
    localparam logic [7:0] PMASK_RST   = 8'h0f;
    localparam logic [7:0] FONT_RST    = 8'h00;
    localparam logic [7:0] MEMMODE_RST = 8'h00;
    localparam logic [7:0] INDEX_MASK  = 8'h07;
    localparam logic [7:0] RESET_MASK  = 8'h03;
    localparam logic [7:0] CLKMODE_MSK = 8'h3d;
    localparam logic [7:0] PMASK_MASK  = 8'h0f;
    localparam logic [7:0] FONT_MASK   = 8'h3f;
    localparam logic [7:0] MEMMODE_MSK = 8'h0e;

    // ------------------------------------------------------------
    // Timing counts (character widths, load periods)
    // ------------------------------------------------------------
    localparam logic [3:0] CHAR_W9     = 4'h9;
    localparam logic [3:0] CHAR_W8     = 4'h8;
    localparam logic [1:0] LOAD_EVERY1 = 2'h0;
    localparam logic [1:0] LOAD_EVERY2 = 2'h1;
    localparam logic [1:0] LOAD_EVERY4 = 2'h3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vsq_io_t;

    typedef struct packed {
        logic        chain4;
        logic        odd_even_off;
        logic        ext_mem;
        logic [3:0]  plane_mask;
    } vsq_memctl_t;

endpackage : vsq_pkg

/* File: vsq_regs.sv */
`timescale 1ns/10ps
`default_nettype none

module vsq_regs #(
    parameter int H_CHARS = 100,
    parameter int V_LINES = 525
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // Host I/O port access
    input  wire vsq_pkg::vsq_io_t      io,
    output var  logic [7:0]            rdata,
    // CPU memory access request
    input  wire logic                  cpu_mem_wr,
    input  wire logic [17:0]           cpu_mem_addr,
    output var  logic [3:0]            cpu_plane_we,
    output var  logic [1:0]            cpu_read_plane,
    output var  logic                  cpu_read_force,
    output var  logic                  cpu_mem_ok,
    // Text attribute decode
    input  wire logic                  attr_bit3,
    output var  logic [15:0]           font_base,
    output var  logic                  fg_intense,
    // Video timing controls
    input  wire logic                  pix_en_raw,
    output var  logic                  seq_halt,
    output var  logic                  seq_async_clr,
    output var  logic                  video_blank,
    output var  logic                  fetch_stop,
    output var  logic                  pix_en,
    output var  logic                  char_en,
    output var  logic                  load_en,
    output var  logic [7:0]            hcount,
    output var  logic [9:0]            vcount
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] index_q, reset_q, clkmode_q, pmask_q, font_q, memmode_q;
    logic       hold_q;
    logic       idx_wr, dat_wr, dat_rd;

    // ------------------------------------------------------------
    // Host port decode
    // ------------------------------------------------------------
    // Only the two sequencer ports answer; every other address is
    // left alone for the neighbouring register groups on the bus
    assign idx_wr = io.wr && (io.addr == vsq_pkg::IDX_PORT);
    assign dat_wr = io.wr && (io.addr == vsq_pkg::DATA_PORT);
    assign dat_rd = io.rd;

    function automatic logic [15:0] font_off(input logic [1:0] hi,
                                             input logic lo,
                                             input logic ext);
        logic [2:0] n;
        n = {hi, lo};
        if (!ext)
            n = {2'b00, lo};
        font_off = {n, 13'h0000};
    endfunction : font_off

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            index_q <= vsq_pkg::INDEX_RST;
        else if (idx_wr)
            index_q <= io.wdata & vsq_pkg::INDEX_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reset_q   <= vsq_pkg::RESET_RST;
            clkmode_q <= vsq_pkg::CLKMODE_RST;
            pmask_q   <= vsq_pkg::PMASK_RST;
            font_q    <= vsq_pkg::FONT_RST;
            memmode_q <= vsq_pkg::MEMMODE_RST;
        end else if (dat_wr) begin
            case (index_q[2:0])
                vsq_pkg::IDX_RESET:
                    reset_q <= io.wdata & vsq_pkg::RESET_MASK;
                vsq_pkg::IDX_CLKMODE:
                    clkmode_q <= io.wdata & vsq_pkg::CLKMODE_MSK;
                vsq_pkg::IDX_PMASK:
                    pmask_q <= io.wdata & vsq_pkg::PMASK_MASK;
                vsq_pkg::IDX_FONT:
                    font_q <= io.wdata & vsq_pkg::FONT_MASK;
                vsq_pkg::IDX_MEMMODE:
                    memmode_q <= io.wdata & vsq_pkg::MEMMODE_MSK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Character counter hold
    // ------------------------------------------------------------
    // Hold is set by any write at index 7, dropped by writes at 0..6;
    // unmapped 5 and 6 still release it, so software can restart the
    // counters without disturbing a live register
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            hold_q <= 1'b0;
        else if (dat_wr)
            hold_q <= (index_q[2:0] == vsq_pkg::IDX_CCHOLD);
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    // Registered so read data stands until the next read strobe;
    // unmapped indices 5, 6 read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            rdata <= 8'h00;
        else if (dat_rd && io.addr == vsq_pkg::IDX_PORT)
            rdata <= index_q;
        else if (dat_rd && io.addr == vsq_pkg::DATA_PORT) begin
            case (index_q[2:0])
                vsq_pkg::IDX_RESET:   rdata <= reset_q;
                vsq_pkg::IDX_CLKMODE: rdata <= clkmode_q;
                vsq_pkg::IDX_PMASK:   rdata <= pmask_q;
                vsq_pkg::IDX_FONT:    rdata <= font_q;
                vsq_pkg::IDX_MEMMODE: rdata <= memmode_q;
                vsq_pkg::IDX_CCHOLD:  rdata <= {7'h00, hold_q};
                default:              rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // CPU memory steering
    // ------------------------------------------------------------
    // Memory mode and plane mask travel together to the steering
    vsq_pkg::vsq_memctl_t memctl;
    assign memctl = '{chain4:       memmode_q[vsq_pkg::MM_CHAIN4_BIT],
                      odd_even_off: memmode_q[vsq_pkg::MM_ODDEVEN_BIT],
                      ext_mem:      memmode_q[vsq_pkg::MM_EXTMEM_BIT],
                      plane_mask:   pmask_q[3:0]};

    // Chain-4 takes precedence: odd/even steering only matters when
    // the low address bits are not already choosing the plane
    logic [3:0] sel_planes;
    always_comb begin
        if (memctl.chain4)
            sel_planes = 4'h1 << cpu_mem_addr[1:0];
        else if (!memctl.odd_even_off)
            sel_planes = cpu_mem_addr[0] ? 4'ha : 4'h5;
        else
            sel_planes = 4'hf;
    end

    logic mem_in_range;
    assign mem_in_range = memctl.ext_mem ||
                          (cpu_mem_addr[17:16] == 2'b00);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cpu_plane_we   <= 4'h0;
            cpu_read_plane <= 2'h0;
            cpu_read_force <= 1'b0;
            cpu_mem_ok     <= 1'b0;
        end else begin
            cpu_plane_we   <= (cpu_mem_wr && mem_in_range) ?
                              (sel_planes & memctl.plane_mask) :
                              4'h0;
            cpu_read_plane <= cpu_mem_addr[1:0];
            cpu_read_force <= memctl.chain4;
            cpu_mem_ok     <= mem_in_range;
        end
    end

    // ------------------------------------------------------------
    // Font selection
    // ------------------------------------------------------------
    logic [15:0] off_a, off_b;
    logic        fonts_differ;
    assign off_a = font_off(font_q[1:0], font_q[4],
                            memmode_q[vsq_pkg::MM_EXTMEM_BIT]);
    assign off_b = font_off(font_q[3:2], font_q[5],
                            memmode_q[vsq_pkg::MM_EXTMEM_BIT]);
    assign fonts_differ = (off_a != off_b);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            font_base  <= 16'h0000;
            fg_intense <= 1'b0;
        end else begin
            // Attribute bit 3 selects map B (secondary) when set
            font_base  <= (fonts_differ && attr_bit3) ? off_b : off_a;
            fg_intense <= fonts_differ ? 1'b0 : attr_bit3;
        end
    end

    // ------------------------------------------------------------
    // Sequencer timing
    // ------------------------------------------------------------
    logic halt, async_clr, dc_div_q, pen, cen, hde_q;
    logic [3:0] dot_q, cwidth;
    logic [1:0] load_cnt_q, load_per;

    // Async reset bit clears without waiting for a character boundary
    assign async_clr = !reset_q[vsq_pkg::RST_ASYNC_BIT];
    assign halt = async_clr || !reset_q[vsq_pkg::RST_SYNC_BIT];
    assign cwidth = clkmode_q[vsq_pkg::CM_NARROW_BIT] ?
                    vsq_pkg::CHAR_W8 : vsq_pkg::CHAR_W9;
    assign load_per = clkmode_q[vsq_pkg::CM_SHIFT4_BIT] ?
                      vsq_pkg::LOAD_EVERY4 :
                      (clkmode_q[vsq_pkg::CM_SLOAD_BIT] ?
                       vsq_pkg::LOAD_EVERY2 : vsq_pkg::LOAD_EVERY1);
    assign pen = pix_en_raw && !halt &&
                 (!clkmode_q[vsq_pkg::CM_DCDIV_BIT] || dc_div_q);
    assign cen = pen && (dot_q == cwidth - 4'h1);

    // Divider phase restarts on halt so both dot rates begin aligned
    always_ff @(posedge ref_clk) begin
        if (!rst_b || halt)
            dc_div_q <= 1'b0;
        else if (pix_en_raw)
            dc_div_q <= !dc_div_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || halt || hold_q)
            dot_q <= 4'h0;
        else if (pen)
            dot_q <= cen ? 4'h0 : dot_q + 4'h1;
    end

    // Load phase only advances while the counter runs; a hold does not
    // clear it, so after a hold the load point need not fall on character zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b || halt)
            load_cnt_q <= 2'h0;
        else if (cen && !hold_q)
            load_cnt_q <= (load_cnt_q == load_per) ? 2'h0 :
                          load_cnt_q + 2'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || halt) begin
            hcount <= 8'h00;
            vcount <= 10'h000;
            hde_q  <= 1'b0;
        end else begin
            if (hold_q)
                hcount <= 8'h00;
            else if (cen)
                hcount <= (hcount == 8'(H_CHARS - 1)) ? 8'h00 :
                          hcount + 8'h01;
            // Line counter steps on end of each line's display run
            hde_q <= cen && !hold_q && (hcount == 8'(H_CHARS - 1));
            if (hde_q)
                vcount <= (vcount == 10'(V_LINES - 1)) ? 10'h000 :
                          vcount + 10'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            seq_halt      <= 1'b0;
            seq_async_clr <= 1'b0;
            video_blank   <= 1'b0;
            fetch_stop    <= 1'b0;
            pix_en        <= 1'b0;
            char_en       <= 1'b0;
            load_en       <= 1'b0;
        end else begin
            seq_halt      <= halt;
            seq_async_clr <= async_clr;
            // Sync keeps running; only pixels and fetches stop
            video_blank   <= clkmode_q[vsq_pkg::CM_SCROFF_BIT];
            fetch_stop    <= clkmode_q[vsq_pkg::CM_SCROFF_BIT];
            pix_en        <= pen;
            char_en       <= cen && !hold_q;
            load_en       <= cen && !hold_q && (load_cnt_q == load_per);
        end
    end

endmodule : vsq_regs

`default_nettype wire

/* File: vsq_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module vsq_regs_sva #(
    parameter int H_CHARS = 100,
    parameter int V_LINES = 525
) (
    // Clock, reset and host port
    input wire logic             ref_clk,
    input wire logic             rst_b,
    input wire vsq_pkg::vsq_io_t io,
    input wire logic [7:0]       rdata,
    // Memory request inputs, memory and timing outputs
    input wire logic             cpu_mem_wr,
    input wire logic [17:0]      cpu_mem_addr,
    input wire logic [3:0]       cpu_plane_we,
    input wire logic             cpu_read_force,
    input wire logic             cpu_mem_ok,
    input wire logic             seq_halt,
    input wire logic             seq_async_clr,
    input wire logic             video_blank,
    input wire logic             fetch_stop,
    input wire logic             load_en,
    input wire logic [7:0]       hcount,
    input wire logic [9:0]       vcount
);
    // ------------------------------------------------------------
    // Shadow of index and counter hold, seen from the port traffic
    // ------------------------------------------------------------
    logic [2:0] idx_q;
    logic       hold_q;
    wire        dwr = io.wr && io.addr == vsq_pkg::DATA_PORT;
    wire        rd_hit = io.rd && (io.addr == vsq_pkg::IDX_PORT
                                   || io.addr == vsq_pkg::DATA_PORT);

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            idx_q <= 3'h0;
        else if (io.wr && io.addr == vsq_pkg::IDX_PORT)
            idx_q <= io.wdata[2:0];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            hold_q <= 1'b0;
        else if (dwr)
            hold_q <= (idx_q == 3'h7);
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    index_read_a: assert property (io.rd && io.addr == vsq_pkg::IDX_PORT
        |=> rdata == {5'h0, $past(idx_q)}) else $error("index readback wrong");
    sync_halt_a: assert property (dwr && idx_q == 3'h0 && !io.wdata[1]
        |-> ##[1:2] seq_halt) else $error("sync halt missing");
    async_clear_a: assert property (dwr && idx_q == 3'h0 && !io.wdata[0]
        |-> ##[1:2] seq_async_clr) else $error("async clear missing");
    screen_off_a: assert property (dwr && idx_q == 3'h1 && io.wdata[5]
        |-> ##[1:2] (video_blank && fetch_stop)) else $error("no blank");
    plane_gate_a: assert property (|cpu_plane_we
        |-> cpu_mem_ok && $past(cpu_mem_wr)) else $error("stray plane write");
    low_range_a: assert property (cpu_mem_wr && cpu_mem_addr[17:16] == 2'h0
        |=> cpu_mem_ok) else $error("low 64KB refused");
    char_hold_a: assert property (hold_q && $past(hold_q)
        |-> hcount == 8'h0) else $error("char counter not held");
    line_freeze_a: assert property (hold_q && $past(hold_q, 2)
        |-> $stable(vcount)) else $error("line counter moved in hold");
    rdata_keep_a: assert property (!$past(rd_hit)
        |-> $stable(rdata)) else $error("read data changed without read");

    cover property (hold_q ##1 hcount == 8'h0);
    cover property (cpu_read_force && |cpu_plane_we);
    cover property (load_en);
endmodule : vsq_regs_sva

bind vsq_regs vsq_regs_sva #(
    .H_CHARS(H_CHARS),
    .V_LINES(V_LINES)
) u_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .io(io), .rdata(rdata),
    .cpu_mem_wr(cpu_mem_wr), .cpu_mem_addr(cpu_mem_addr),
    .cpu_plane_we(cpu_plane_we), .cpu_read_force(cpu_read_force),
    .cpu_mem_ok(cpu_mem_ok), .seq_halt(seq_halt),
    .seq_async_clr(seq_async_clr), .video_blank(video_blank),
    .fetch_stop(fetch_stop), .load_en(load_en), .hcount(hcount),
    .vcount(vcount)
);

`default_nettype wire

/* File: vsq_host.sv */
`timescale 1ns/10ps
`default_nettype none

module vsq_host (
    // Clock
    input  wire logic             ref_clk,
    // Port bus
    output var  vsq_pkg::vsq_io_t io,
    input  wire logic [7:0]       rdata
);
    // ------------------------------------------------------------
    // Host port cycles
    // ------------------------------------------------------------
    initial io = '0;

    task automatic put(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        io = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        // Released lines must not keep showing the last value
        io = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : put

    task automatic reg_wr(input logic [2:0] i, input logic [7:0] d);
        put(1'b1, vsq_pkg::IDX_PORT, {5'h0, i});
        put(1'b1, vsq_pkg::DATA_PORT, d);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] i, output logic [7:0] d);
        put(1'b1, vsq_pkg::IDX_PORT, {5'h0, i});
        put(1'b0, vsq_pkg::DATA_PORT, 8'h00);
        d = rdata;
    endtask : reg_rd

    // Short synchronous reset around a mode change keeps memory intact
    task automatic set_clk(input logic [7:0] d);
        reg_wr(3'h0, 8'h01);
        reg_wr(3'h1, d);
        reg_wr(3'h0, 8'h03);
    endtask : set_clk
endmodule : vsq_host

`default_nettype wire

/* File: vga_sequencer_regs_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module vga_sequencer_regs_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b, cpu_mem_wr, attr_bit3, pix_en_raw, cpu_read_force;
    logic cpu_mem_ok, fg_intense, seq_halt, seq_async_clr, video_blank;
    logic fetch_stop, pix_en, char_en, load_en;
    logic [7:0] rdata, hcount;
    logic [17:0] cpu_mem_addr;
    logic [3:0] cpu_plane_we;
    logic [1:0] cpu_read_plane;
    logic [15:0] font_base;
    logic [9:0] vcount;
    vsq_pkg::vsq_io_t io;
    int num_errors = 0, cmp_count = 0, cyc = 0;

    vsq_regs #(.H_CHARS(4), .V_LINES(3)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .io(io), .rdata(rdata),
        .cpu_mem_wr(cpu_mem_wr), .cpu_mem_addr(cpu_mem_addr),
        .cpu_plane_we(cpu_plane_we), .cpu_read_plane(cpu_read_plane),
        .cpu_read_force(cpu_read_force), .cpu_mem_ok(cpu_mem_ok),
        .attr_bit3(attr_bit3), .font_base(font_base),
        .fg_intense(fg_intense), .pix_en_raw(pix_en_raw),
        .seq_halt(seq_halt), .seq_async_clr(seq_async_clr),
        .video_blank(video_blank), .fetch_stop(fetch_stop),
        .pix_en(pix_en), .char_en(char_en), .load_en(load_en),
        .hcount(hcount), .vcount(vcount));
    vsq_host u_host (.ref_clk(ref_clk), .io(io), .rdata(rdata));

    // ------------------------------------------------------------
    // Clock, checking and closing
    // ------------------------------------------------------------
    always #12.5 ref_clk = ~ref_clk;

    task automatic stop_test;
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            stop_test;
        end
    end

    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk

    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tk

    task automatic t_regs;
        logic [7:0] d;
        logic [7:0] rv [5] = '{vsq_pkg::RESET_RST, vsq_pkg::CLKMODE_RST,
            vsq_pkg::PMASK_RST, vsq_pkg::FONT_RST, vsq_pkg::MEMMODE_RST};
        logic [7:0] mk [6] = '{vsq_pkg::RESET_MASK, vsq_pkg::CLKMODE_MSK,
            vsq_pkg::PMASK_MASK, vsq_pkg::FONT_MASK, vsq_pkg::MEMMODE_MSK, 8'h00};
        u_host.put(1'b0, vsq_pkg::IDX_PORT, 8'h00);
        chk(rdata === vsq_pkg::INDEX_RST, "index reset");
        for (int i = 0; i < 5; i++) begin
            u_host.reg_rd(i[2:0], d);
            chk(d === rv[i], "reset value");
        end
        for (int i = 0; i < 6; i++) u_host.reg_wr(i[2:0], 8'hff);
        for (int i = 0; i < 6; i++) begin
            u_host.reg_rd(i[2:0], d);
            chk(d === mk[i], "writable bits");
        end
        u_host.put(1'b1, vsq_pkg::IDX_PORT, 8'hff);
        u_host.put(1'b0, vsq_pkg::IDX_PORT, 8'h00);
        chk(rdata === 8'h07, "index width");
        u_host.put(1'b0, 16'h03c6, 8'h00);
        chk(rdata === 8'h07, "stray read");
        u_host.set_clk(8'h00);
    endtask : t_regs

    task automatic t_ctl;
        u_host.reg_wr(3'h0, 8'h01);
        tk(2);
        chk(seq_halt === 1'b1 && seq_async_clr === 1'b0, "sync halt");
        chk(pix_en === 1'b0 && char_en === 1'b0, "halted");
        u_host.reg_wr(3'h0, 8'h02);
        tk(2);
        chk(seq_async_clr === 1'b1 && seq_halt === 1'b1, "async");
        chk(hcount === 8'h0 && vcount === 10'h0, "clear");
        u_host.reg_wr(3'h0, 8'h03);
        u_host.set_clk(8'h20);
        tk(2);
        chk(video_blank === 1'b1 && fetch_stop === 1'b1, "blank");
        u_host.set_clk(8'h00);
        tk(2);
        chk(video_blank === 1'b0 && seq_halt === 1'b0, "run");
        chk(pix_en === 1'b1, "pixel rate");
        pix_en_raw = 1'b0;
        tk(2);
        chk(pix_en === 1'b0 && char_en === 1'b0, "pixel gate");
        pix_en_raw = 1'b1;
    endtask : t_ctl

    // Cycles between two pulses of char_en (s=0) or load_en (s=1)
    task automatic period(input bit s, output int n);
        repeat (2) begin
            n = 1;
            tk(1);
            while (n < 200 && (s ? load_en : char_en) !== 1'b1) begin
                n++;
                tk(1);
            end
        end
    endtask : period

    task automatic t_clk;
        int n;
        logic p;
        logic [7:0] md [6] = '{8'h00, 8'h01, 8'h04, 8'h10, 8'h14, 8'h09};
        int cp [6] = '{9, 8, 9, 9, 9, 16};
        int lp [6] = '{9, 8, 18, 36, 36, 16};
        for (int i = 0; i < 6; i++) begin
            u_host.set_clk(md[i]);
            period(1'b0, n);
            chk(n === cp[i], "char period");
            period(1'b1, n);
            chk(n === lp[i], "load period");
        end
        p = pix_en;
        tk(1);
        chk(pix_en === !p, "half rate");
    endtask : t_clk

    task automatic t_mem;
        logic [7:0] mm [7] = '{8'h08, 8'h08, 8'h00, 8'h00, 8'h04, 8'h04, 8'h06};
        logic [3:0] mk [7] = '{4'hf, 4'h7, 4'hf, 4'hf, 4'h5, 4'hf, 4'hf};
        logic [17:0] ad [7] = '{18'h3, 18'h3, 18'h1, 18'h2, 18'h1,
                                18'h10000, 18'h10000};
        logic [3:0] we [7] = '{4'h8, 4'h0, 4'ha, 4'h5, 4'h5, 4'h0, 4'hf};
        for (int i = 0; i < 7; i++) begin
            u_host.reg_wr(3'h4, mm[i]);
            u_host.reg_wr(3'h2, {4'h0, mk[i]});
            cpu_mem_addr = ad[i];
            cpu_mem_wr = 1'b1;
            tk(1);
            cpu_mem_wr = 1'b0;
            chk(cpu_plane_we === we[i], "plane we");
            chk(cpu_mem_ok === (i != 5), "range");
            chk(cpu_read_force === mm[i][3]
                && cpu_read_plane === ad[i][1:0], "chain");
        end
    endtask : t_mem

    task automatic t_font;
        logic [7:0] mm [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00};
        logic [7:0] fs [5] = '{8'h00, 8'h01, 8'h2c, 8'h13, 8'h13};
        logic at [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [15:0] fb [5] = '{16'h0, 16'h4000, 16'he000, 16'he000, 16'h2000};
        for (int i = 0; i < 5; i++) begin
            u_host.reg_wr(3'h4, mm[i]);
            u_host.reg_wr(3'h3, fs[i]);
            attr_bit3 = at[i];
            tk(2);
            chk(font_base === fb[i], "font base");
            chk(fg_intense === (i == 0), "intensity");
        end
    endtask : t_font

    task automatic t_hold;
        logic [7:0] d;
        logic [9:0] v;
        int n;
        u_host.reg_wr(3'h7, 8'h5a);
        tk(3);
        v = vcount;
        u_host.reg_rd(3'h7, d);
        chk(d === 8'h01, "hold flag");
        repeat (20) begin
            tk(1);
            chk(hcount === 8'h0 && vcount === v, "held");
        end
        u_host.reg_wr(3'h6, 8'h00);
        n = 0;
        repeat (100) begin
            tk(1);
            if (hcount !== 8'h0)
                n++;
        end
        chk(n > 0, "counter restart");
        chk(vcount !== v, "line restart");
    endtask : t_hold

    initial begin
        rst_b = 1'b0;
        cpu_mem_wr = 1'b0;
        cpu_mem_addr = '0;
        attr_bit3 = 1'b0;
        pix_en_raw = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        t_regs;
        t_ctl;
        t_clk;
        t_mem;
        t_font;
        t_hold;
        rst_b = 1'b0;
        tk(2);
        rst_b = 1'b1;
        t_regs;
        stop_test;
    end
endmodule : vga_sequencer_regs_tb_top

`default_nettype wire
